// [logic/aopc_consts.vh]
// Operation
// - Reset acts at once, without clock.
// - Reset clears state, bus low, valid high.
// - Valid goes low second rising edge after.
// - Shared clock and reset give lockstep devices.
// - Output is 16-bit two's complement.
// - Over positive scale clips 7FFF, flag set.
// - Under negative scale clips 8000, flag set.
// - Flag rises on delivering valid edge.
// - Flag clears on first in-range edge.
// - Valid falling edge marks a new sample.
// - Bus driven only when both strobes low.
// - Reference select high disables internal reference.
// - All conversion timed from sample clock.
// - Decimation select low decimates by eight.
// - Decimation select high decimates by four.
// - Power-down low stops conversion and internal reference.
`ifndef AOPC_CONSTS_VH
`define AOPC_CONSTS_VH
`define AOPC_WIDTH      16
`define AOPC_ACC_W      20
`define AOPC_POS_FULL   16'h7FFF
`define AOPC_NEG_FULL   16'h8000
`define AOPC_DECIM_LO   4'h8
`define AOPC_DECIM_HI   4'h4
`define AOPC_ADR_CTRL   4'h0
`define AOPC_ADR_STAT   4'h4
`define AOPC_ADR_DATA   4'h8
`define AOPC_ADR_RAW    4'hC
`define AOPC_CTRL_RST   16'h0001
`endif

// [logic/aopc_decim.v]
`timescale 1ns/1ps
// ***********************************************************************
// Decimator: accumulates modulator words, clips and flags.
// ***********************************************************************
`include "aopc_consts.vh"
module aopc_decim
(
  input  wire                   CLK,
  input  wire                   RST,
  input  wire                   EN,
  input  wire                   DECIM_SEL,
  input  wire signed [15:0]     MOD_IN,
  output reg                    STROBE,
  output reg  [15:0]            WORD,
  output reg                    RANGE
);
  reg signed [19:0] acc_ff;
  reg [3:0]         cnt_ff;
  reg               phase_ff;
  wire [3:0]        ratio;
  wire signed [19:0] sum;
  wire signed [19:0] avg;
  assign ratio = DECIM_SEL ? `AOPC_DECIM_HI : `AOPC_DECIM_LO;
  assign sum = acc_ff + {{4{MOD_IN[15]}}, MOD_IN};
  assign avg = DECIM_SEL ? (sum >>> 1) : (sum >>> 2);
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      acc_ff   <= 20'h00000;
      cnt_ff   <= 4'h0;
      phase_ff <= 1'b0;
      STROBE   <= 1'b0;
      WORD     <= 16'h0000;
      RANGE    <= 1'b0;
    end
    else if (EN)
    begin
      phase_ff <= 1'b1;
      STROBE   <= 1'b0;
      if (phase_ff && (cnt_ff >= ratio - 4'h1))
      begin
        cnt_ff <= 4'h0;
        acc_ff <= 20'h00000;
        STROBE <= 1'b1;
        if (avg > $signed(20'h07FFF))
        begin
          WORD  <= `AOPC_POS_FULL;
          RANGE <= 1'b1;
        end
        else if (avg < $signed(20'hF8000))
        begin
          WORD  <= `AOPC_NEG_FULL;
          RANGE <= 1'b1;
        end
        else
        begin
          WORD  <= avg[15:0];
          RANGE <= 1'b0;
        end
      end
      else if (phase_ff)
      begin
        cnt_ff <= cnt_ff + 4'h1;
        acc_ff <= sum;
      end
    end
    else
      STROBE <= 1'b0;
  end
endmodule // aopc_decim

// [logic/aopc_top.v]
`timescale 1ns/1ps
// ***********************************************************************
// Output port control top.
// ***********************************************************************
`include "aopc_consts.vh"
module aopc_top
(
  input  wire                   CLK,
  input  wire                   SYS_RST,
  input  wire                   RESET_N,
  input  wire                   POWER_DOWN_N,
  input  wire                   DECIM_SELECT,
  input  wire                   EXT_REF_SELECT,
  input  wire [15:0]            MOD_IN,
  input  wire                   CS_N,
  input  wire                   RD_N,
  output wire [15:0]            DOUT_O,
  output wire                   DOUT_OE,
  output reg                    SAMPLE_VALID_N,
  output reg                    RANGE_FLAG,
  output wire                   INT_REF_EN,
  input  wire [3:0]             AWADDR,
  input  wire                   AWVALID,
  output wire                   AWREADY,
  input  wire [31:0]            WDATA,
  input  wire [3:0]             WSTRB,
  input  wire                   WVALID,
  output wire                   WREADY,
  output reg  [1:0]             BRESP,
  output reg                    BVALID,
  input  wire                   BREADY,
  input  wire [3:0]             ARADDR,
  input  wire                   ARVALID,
  output wire                   ARREADY,
  output reg  [31:0]            RDATA,
  output reg  [1:0]             RRESP,
  output reg                    RVALID,
  input  wire                   RREADY
);
  // ***********************************************************************
  // Reset combine and pin synchronisers.
  // ***********************************************************************
  reg        ctrl_rst_ff;
  reg        pd_s1_ff, pd_s2_ff;
  reg        dec_s1_ff, dec_s2_ff;
  reg        ref_s1_ff, ref_s2_ff;
  reg        cs_s1_ff, cs_s2_ff;
  reg        rd_s1_ff, rd_s2_ff;
  reg [15:0] mod_s1_ff, mod_s2_ff;
  reg [15:0] dout_ff;
  reg        seen_ff;
  reg        seen2_ff;
  wire       dig_rst;
  wire       strobe;
  wire [15:0] word;
  wire       rng;
  assign dig_rst = SYS_RST | ~RESET_N | ctrl_rst_ff;
  always @(posedge CLK)
  begin
    pd_s1_ff  <= POWER_DOWN_N;
    pd_s2_ff  <= pd_s1_ff;
    dec_s1_ff <= DECIM_SELECT;
    dec_s2_ff <= dec_s1_ff;
    ref_s1_ff <= EXT_REF_SELECT;
    ref_s2_ff <= ref_s1_ff;
    cs_s1_ff  <= CS_N;
    cs_s2_ff  <= cs_s1_ff;
    rd_s1_ff  <= RD_N;
    rd_s2_ff  <= rd_s1_ff;
    mod_s1_ff <= MOD_IN;
    mod_s2_ff <= mod_s1_ff;
  end
  assign INT_REF_EN = ~ref_s2_ff & pd_s2_ff;
  // ***********************************************************************
  // Conversion path, timed from CLK only.
  // ***********************************************************************
  aopc_decim u_decim
  (
    .CLK       (CLK),
    .RST       (dig_rst),
    .EN        (pd_s2_ff),
    .DECIM_SEL (dec_s2_ff),
    .MOD_IN    (mod_s2_ff),
    .STROBE    (strobe),
    .WORD      (word),
    .RANGE     (rng)
  );
  // ***********************************************************************
  // Sample-valid, data and range outputs.
  // ***********************************************************************
  always @(posedge CLK or posedge dig_rst)
  begin
    if (dig_rst)
    begin
      SAMPLE_VALID_N <= 1'b1;
      RANGE_FLAG     <= 1'b0;
      dout_ff        <= 16'h0000;
      seen_ff        <= 1'b0;
      seen2_ff       <= 1'b0;
    end
    else
    begin
      seen_ff  <= 1'b1;
      seen2_ff <= seen_ff;
      if (!seen_ff)
        SAMPLE_VALID_N <= 1'b1;
      else if (!seen2_ff)
        SAMPLE_VALID_N <= 1'b0;
      else if (strobe)
      begin
        SAMPLE_VALID_N <= 1'b0;
        dout_ff        <= word;
        RANGE_FLAG     <= rng;
      end
      else
        SAMPLE_VALID_N <= 1'b1;
    end
  end
  assign DOUT_OE = ~cs_s2_ff & ~rd_s2_ff & ~dig_rst;
  assign DOUT_O  = dig_rst ? 16'h0000 : dout_ff;
  // ***********************************************************************
  // AXI4-Lite slave.
  // ***********************************************************************
  reg        aw_ff, w_ff;
  reg [3:0]  awa_ff;
  reg [31:0] wd_ff;
  assign AWREADY = ~aw_ff & ~BVALID;
  assign WREADY  = ~w_ff & ~BVALID;
  assign ARREADY = ~RVALID;
  always @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      aw_ff <= 1'b0;
      w_ff  <= 1'b0;
      awa_ff <= 4'h0;
      wd_ff <= 32'h00000000;
      BVALID <= 1'b0;
      BRESP  <= 2'b00;
      RVALID <= 1'b0;
      RRESP  <= 2'b00;
      RDATA  <= 32'h00000000;
      ctrl_rst_ff <= 1'b0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_ff  <= 1'b1;
        awa_ff <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_ff  <= 1'b1;
        wd_ff <= WDATA;
      end
      if (aw_ff && w_ff)
      begin
        aw_ff  <= 1'b0;
        w_ff   <= 1'b0;
        BVALID <= 1'b1;
        if (awa_ff == `AOPC_ADR_CTRL)
        begin
          BRESP <= 2'b00;
          ctrl_rst_ff <= wd_ff[0];
        end
        else
          BRESP <= 2'b10;
      end
      else if (BVALID && BREADY)
        BVALID <= 1'b0;
      if (ARVALID && ARREADY)
      begin
        RVALID <= 1'b1;
        RRESP  <= 2'b00;
        case (ARADDR)
          `AOPC_ADR_CTRL: RDATA <= {31'h00000000, ctrl_rst_ff};
          `AOPC_ADR_STAT: RDATA <= {29'h00000000, INT_REF_EN,
                                    RANGE_FLAG, SAMPLE_VALID_N};
          `AOPC_ADR_DATA: RDATA <= {16'h0000, dout_ff};
          default:
          begin
            RDATA <= 32'h00000000;
            RRESP <= 2'b10;
          end
        endcase
      end
      else if (RVALID && RREADY)
        RVALID <= 1'b0;
    end
  end
endmodule // aopc_top

// [testbench/aopc_checker.sv]
`timescale 1ns/1ps
// ****
// Watches the sample port of the block.
// ****
module aopc_checker (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        RESET_N,
  input wire logic        POWER_DOWN_N,
  input wire logic        DECIM_SELECT,
  input wire logic        CS_N,
  input wire logic        RD_N,
  input wire logic [15:0] DOUT_O,
  input wire logic        DOUT_OE,
  input wire logic        SAMPLE_VALID_N,
  input wire logic        RANGE_FLAG,
  input wire logic        INT_REF_EN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST || !RESET_N);
  sequence s_fall;
    $fell(SAMPLE_VALID_N);
  endsequence
  a_reset_clear: assert property ($rose(RESET_N) |-> SAMPLE_VALID_N
    && !RANGE_FLAG && DOUT_O == 16'h0000) else $error("reset state");
  a_first_valid: assert property ($rose(RESET_N) && POWER_DOWN_N
    |-> ##2 s_fall) else $error("first sample late");
  a_valid_pulse: assert property (s_fall |=> SAMPLE_VALID_N)
    else $error("valid pulse too long");
  a_period_eight: assert property ((!DECIM_SELECT && POWER_DOWN_N)[*4]
    ##0 s_fall ##1 (!DECIM_SELECT && POWER_DOWN_N)[*7] |=> s_fall)
    else $error("period not eight");
  a_period_four: assert property ((DECIM_SELECT && POWER_DOWN_N)[*4]
    ##0 s_fall ##1 (DECIM_SELECT && POWER_DOWN_N)[*3] |=> s_fall)
    else $error("period not four");
  a_oe_off: assert property ((CS_N || RD_N)[*5] |-> !DOUT_OE)
    else $error("bus driven");
  a_oe_on: assert property ((!CS_N && !RD_N && POWER_DOWN_N)[*3]
    |-> DOUT_OE) else $error("bus not driven");
  a_range_edge: assert property ($changed(RANGE_FLAG) |-> s_fall)
    else $error("flag moved off sample edge");
  a_pd_halts: assert property ((!POWER_DOWN_N)[*5] |-> SAMPLE_VALID_N
    && !INT_REF_EN) else $error("still active in power down");
endmodule // aopc_checker
bind aopc_top aopc_checker chk (.*);

// [testbench/aopc_host.sv]
`timescale 1ns/1ps
// ****
// Reading controller on the sample bus.
// ****
module aopc_host (
  input wire logic        CLK,
  input wire logic        SAMPLE_VALID_N,
  input wire logic [15:0] DOUT_O,
  input wire logic        DOUT_OE,
  output logic            CS_N,
  output logic            RD_N,
  output logic [15:0]     word,
  output int              periods
);
  wire [15:0] bus = DOUT_OE ? DOUT_O : ~word;
  initial periods = 0;
  always @(posedge CLK)
    if (SAMPLE_VALID_N === 1'b0)
      periods <= periods + 1;
  initial
  begin
    CS_N = 1'b1;
    RD_N = 1'b1;
    word = '0;
    forever
    begin
      @(posedge CLK);
      if (SAMPLE_VALID_N === 1'b0)
      begin
        CS_N <= 1'b0;
        RD_N <= 1'b0;
        for (int n = 0; n < 8 && DOUT_OE !== 1'b1; n++) @(posedge CLK);
        @(posedge CLK);
        word <= bus;
        CS_N <= 1'b1;
        RD_N <= 1'b1;
      end
    end
  end
endmodule // aopc_host

// [testbench/aopc_top_tb.sv]
`timescale 1ns/1ps
`include "aopc_consts.vh"
// ****
// Bench for the output port control.
// ****
module aopc_top_tb;
  logic        CLK = 0, SYS_RST = 1, RESET_N = 0, POWER_DOWN_N = 1;
  logic        DECIM_SELECT = 0, EXT_REF_SELECT = 0, CS_N, RD_N;
  logic        AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [3:0]  AWADDR = '0, ARADDR = '0, WSTRB = 4'hF;
  logic [31:0] WDATA = '0, RDATA;
  logic [15:0] MOD_IN = '0, DOUT_O, word;
  logic [1:0]  BRESP, RRESP;
  logic        DOUT_OE, SAMPLE_VALID_N, RANGE_FLAG, INT_REF_EN;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID;
  int          fail_count = 0, checks_done = 0, periods;
  aopc_top dut (.*);
  aopc_host host (.*);
  initial forever #5 CLK = ~CLK;
  task automatic chk(input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wait_periods(input int n);
    int t;
    t = periods + n;
    repeat (n * 20) if (periods < t) @(posedge CLK);
    chk(periods >= t, 1);
    if (periods < t) report_and_stop();
  endtask
  task automatic axi(input logic wr, input logic [3:0] a,
                     input logic [1:0] er, input logic [31:0] ed, m);
    logic aw, w, ar, done;
    logic [1:0] rsp;
    logic [31:0] d;
    int n;
    @(posedge CLK);
    {AWADDR, ARADDR, WDATA} <= {a, a, ed};
    {AWVALID, WVALID, BREADY} <= {3{wr}};
    {ARVALID, RREADY} <= {2{!wr}};
    done = 0;
    for (n = 0; n < 40 && !done; n++)
    begin
      @(negedge CLK);
      {aw, w, ar} = {AWVALID & AWREADY, WVALID & WREADY, ARVALID & ARREADY};
      done = wr ? BVALID : RVALID;
      rsp = wr ? BRESP : RRESP;
      d = RDATA;
      @(posedge CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      if (ar) ARVALID <= 1'b0;
      if (done) {BREADY, RREADY} <= 2'b00;
    end
    chk(done, 1);
    if (!done) report_and_stop();
    chk(rsp, er);
    chk(d & m, ed & m);
  endtask
  task automatic t_codes;
    logic [15:0] tab [6] = '{16'h4000, 16'h1234, 16'h9000,
                             16'hC000, 16'h3FFF, 16'h7000};
    logic [16:0] e;
    int s, c, n;
    for (int d = 0; d < 2; d++)
    begin
      DECIM_SELECT <= d[0];
      foreach (tab[i])
      begin
        s = 2 * $signed(tab[i]);
        e = {1'b0, s[15:0]};
        if (s > 32767) e = {1'b1, `AOPC_POS_FULL};
        if (s < -32768) e = {1'b1, `AOPC_NEG_FULL};
        MOD_IN <= tab[i];
        wait_periods(48);
        chk(RANGE_FLAG, e[16]);
        chk(word, e[15:0]);
      end
      c = periods;
      for (n = 0; n < 64 && periods < c + 4; n++) @(posedge CLK);
      chk(n, d ? 16 : 32);
    end
    $display("codes done");
  endtask
  task automatic t_ref;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge CLK);
      {POWER_DOWN_N, EXT_REF_SELECT} <= i[1:0];
      repeat (6) @(posedge CLK);
      chk(INT_REF_EN, i[1] & !i[0]);
    end
    $display("ref done");
  endtask
  task automatic t_regs;
    wait_periods(8);
    axi(1, `AOPC_ADR_CTRL, 2'b00, '0, '0);
    axi(1, `AOPC_ADR_STAT, 2'b10, '0, '0);
    axi(0, `AOPC_ADR_RAW, 2'b10, '0, 32'hFFFFFFFF);
    axi(0, `AOPC_ADR_STAT, 2'b00, '0, 32'h4);
    axi(0, `AOPC_ADR_DATA, 2'b00, 32'h7FFF, 32'hFFFF);
    $display("regs done");
  endtask
  task automatic t_reset;
    int n;
    @(negedge CLK);
    RESET_N = 1'b0;
    #1;
    chk({SAMPLE_VALID_N, DOUT_OE, RANGE_FLAG, DOUT_O}, 19'h40000);
    repeat (3) @(negedge CLK);
    RESET_N = 1'b1;
    for (n = 0; n < 10 && SAMPLE_VALID_N !== 1'b0; n++) @(negedge CLK);
    chk(n, 2);
    $display("reset done");
  endtask
  initial
  begin
    repeat (20) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(negedge CLK);
    RESET_N = 1'b1;
    wait_periods(48);
    t_codes();
    t_ref();
    t_regs();
    t_reset();
    report_and_stop();
  end
endmodule // aopc_top_tb
